// >>> rtl/cmmp_pkg.sv
package cmmp_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_INSTR = 8'h04;
  localparam logic [7:0] OFS_REPEAT = 8'h08;
  localparam logic [7:0] OFS_OPA = 8'h0C;
  localparam logic [7:0] OFS_OPB = 8'h10;
  localparam logic [7:0] OFS_SUM = 8'h14;
  localparam logic [7:0] OFS_PROD = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1C;
  localparam logic [7:0] OFS_OVC = 8'h20;
  localparam logic [7:0] OFS_PROT = 8'h24;
  localparam logic [7:0] OFS_PC = 8'h28;
  localparam logic [7:0] OFS_MEM = 8'h40;
  localparam int MEM_WORDS = 16;
  // field positions
  localparam int CTRL_SAT = 0;
  localparam int CTRL_PSHIFT_LO = 4;
  localparam int CTRL_EMU_EN = 8;
  localparam int CTRL_DEBUG_MASK = 9;
  localparam int ST_Z = 0;
  localparam int ST_N = 1;
  localparam int ST_C = 2;
  localparam int ST_V = 3;
  localparam int ST_PW = 4;
  localparam int ST_MASK = 5;
  localparam int ST_HALT = 6;
  localparam int ST_BUSY = 7;
  localparam int ST_TRAP = 8;
  // reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [21:0] PC_RST = 22'h00_0000;
  localparam logic RESET_IRQ_MASK = 1'b1;
  // opcodes
  localparam logic [15:0] OP_DUAL_MAC = 16'h564B;
  localparam logic [7:0] OP_MAC_W2 = 8'hC7;
  localparam logic [7:0] OP_MAC_W2_INC = 8'h87;
  localparam logic [7:0] OP_SHIFT_COPY = 8'hA5;
  localparam logic [15:0] OP_PW_EN = 16'h7622;
  localparam logic [15:0] OP_PW_DIS = 16'h761A;
  localparam logic [15:0] OP_IRQ_UNMASK = 16'h2910;
  localparam logic [15:0] OP_BKPT = 16'h7625;
  localparam logic [15:0] OP_IRQ_RET = 16'h7602;
  // operand field values that select register addressing
  localparam logic [3:0] LOC_REG_MODE = 4'hA;
  // extra cycles after the iteration phase
  // busy time is one cycle per iteration, these waits and one closing cycle
  localparam logic [1:0] WAIT_MAC = 2'h1;
  localparam logic [1:0] WAIT_PW = 2'h2;
  localparam logic [1:0] WAIT_UNMASK = 2'h0;
  localparam logic [1:0] WAIT_NONE = 2'h0;
  localparam logic [31:0] SAT_POS = 32'h7FFF_FFFF;
  localparam logic [31:0] SAT_NEG = 32'h8000_0000;

  typedef enum {ST_IDLE, ST_EXEC, ST_HALTED} cmmp_state_t;

  typedef struct packed {
    logic [7:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } cmmp_avs_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } cmmp_avs_rsp_t;
endpackage : cmmp_pkg

// >>> rtl/cmmp_core.sv
// The Avalon-MM interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
// What this block does
// - dual MAC: high halves into sum register, low halves into product register
// - after dual MAC, zero flag set when sum register is zero
// - after dual MAC, negative flag copies sum register bit 31
// - carry flag follows carry out of the sum accumulation
// - overflow flag set on sum overflow, otherwise left unchanged
// - saturation off: positive overflow increments overflow counter, negative decrements
// - saturation on: sum clamps to extreme values; product never saturates
// - product shift applies to both sum and product accumulations
// - positive shift is logical left, negative is arithmetic right
// - repeated dual MAC runs N+1 times; zero, negative and carry flags and overflow counter reflect final sum
// - repeated dual MAC sets overflow flag on any intermediate overflow
// - shift-copy writes word to next address, flags untouched
// - shift-copy with register addressing raises illegal-instruction trap
// - repeated shift-copy runs N+1 times
// - protected-write enable sets the bit, four cycles
// - protected bit gates writes only, reads always succeed
// - interrupt or trap saves protected bit then clears it
// - interrupt return restores the saved protected bit
// - debug port access overrides the protected bit
// - protected-write disable clears the bit, four cycles
// - irq unmask clears global mask, two cycles
// - breakpoint halts when emulator attached and enabled, ignoring debug mask
// - halting breakpoint leaves program counter on itself
// - otherwise breakpoint acts as no-operation and advances counter
// - non-repeatable op after repeat prefix clears tally, runs once
module cmmp_core (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic ce,
  // register bus
  input wire cmmp_pkg::cmmp_avs_req_t avs_req,
  output cmmp_pkg::cmmp_avs_rsp_t avs_rsp,
  input wire logic dbg_access,
  // interrupt and emulator
  input wire logic irq_req,
  output logic irq_ack,
  input wire logic emu_attached_pin,
  output logic core_halted
);
  cmmp_pkg::cmmp_state_t state_reg;
  logic [31:0] ctrl_reg, opa_reg, opb_reg, sum_reg, prod_reg, prot_reg, instr_reg, rdata_reg;
  logic [15:0] tally_reg, iter_reg;
  logic [1:0] wait_reg;
  logic [5:0] ovc_reg;
  logic [21:0] pc_reg;
  logic z_reg, n_reg, c_reg, v_reg, pw_reg, pw_saved_reg, mask_reg, trap_reg, ack_reg;
  logic emu_s1_reg, emu_s2_reg;
  logic [15:0] mem_reg [cmmp_pkg::MEM_WORDS];

  // bus decode: one wait cycle, instruction writes stall while busy
  logic bus_req, is_instr_wr, acc_ok, wr_ok;
  assign bus_req = avs_req.read | avs_req.write;
  assign is_instr_wr = avs_req.write && avs_req.address == cmmp_pkg::OFS_INSTR;
  assign acc_ok = ce && bus_req && !ack_reg && !(is_instr_wr && state_reg != cmmp_pkg::ST_IDLE);
  assign wr_ok = acc_ok && avs_req.write;
  assign avs_rsp.waitrequest = bus_req && !ack_reg;
  assign avs_rsp.readdata = rdata_reg;
  assign core_halted = state_reg == cmmp_pkg::ST_HALTED;

  // decode of the latched instruction
  logic is_dual_mac, is_shift_copy, copy_reg_mode, rep_op;
  logic [3:0] loc_idx;
  assign is_dual_mac = instr_reg[31:16] == cmmp_pkg::OP_DUAL_MAC &&
    (instr_reg[15:8] == cmmp_pkg::OP_MAC_W2 || instr_reg[15:8] == cmmp_pkg::OP_MAC_W2_INC);
  assign is_shift_copy = instr_reg[31:24] == cmmp_pkg::OP_SHIFT_COPY;
  assign copy_reg_mode = instr_reg[23:20] == cmmp_pkg::LOC_REG_MODE;
  assign loc_idx = instr_reg[19:16];
  assign rep_op = is_dual_mac || is_shift_copy;

  // start of an instruction: latched on the cycle after the INSTR write
  logic start_reg;
  logic last_iter, in_iter_reg, finish;
  assign last_iter = in_iter_reg && iter_reg == 16'h0000;
  assign finish = state_reg == cmmp_pkg::ST_EXEC && !in_iter_reg && wait_reg == 2'h0;

  // product shift and dual multiply
  logic signed [3:0] pshift_amt;
  logic signed [31:0] prod_hi, prod_lo, sh_hi, sh_lo;
  assign pshift_amt = ctrl_reg[cmmp_pkg::CTRL_PSHIFT_LO +: 4];
  assign prod_hi = $signed(opa_reg[31:16]) * $signed(opb_reg[31:16]);
  assign prod_lo = $signed(opa_reg[15:0]) * $signed(opb_reg[15:0]);

  function automatic logic [31:0] pshift(input logic [31:0] v, input logic signed [3:0] s);
    logic [3:0] mag;
    mag = s[3] ? 4'(-s) : 4'(s);
    if (s[3]) begin
      pshift = 32'($signed(v) >>> mag);
    end else begin
      pshift = v << mag;
    end
  endfunction : pshift

  assign sh_hi = pshift(prod_hi, pshift_amt);
  assign sh_lo = pshift(prod_lo, pshift_amt);

  logic [32:0] sum_wide;
  logic [31:0] sum_raw, sum_new;
  logic ovf_pos, ovf_neg, ovf;
  assign sum_wide = {1'b0, sum_reg} + {1'b0, sh_hi};
  assign sum_raw = sum_wide[31:0];
  assign ovf_pos = !sum_reg[31] && !sh_hi[31] && sum_raw[31];
  assign ovf_neg = sum_reg[31] && sh_hi[31] && !sum_raw[31];
  assign ovf = ovf_pos || ovf_neg;
  always_comb begin
    sum_new = sum_raw;
    if (ctrl_reg[cmmp_pkg::CTRL_SAT] && ovf_pos) begin
      sum_new = cmmp_pkg::SAT_POS;
    end else if (ctrl_reg[cmmp_pkg::CTRL_SAT] && ovf_neg) begin
      sum_new = cmmp_pkg::SAT_NEG;
    end
  end
  logic mac_step, copy_step, emu_live;
  assign mac_step = in_iter_reg && is_dual_mac;
  assign copy_step = in_iter_reg && is_shift_copy && !copy_reg_mode;
  assign emu_live = emu_s2_reg && ctrl_reg[cmmp_pkg::CTRL_EMU_EN];
  logic take_irq, trap_now, first_step;
  assign first_step = start_reg;
  assign trap_now = start_reg && is_shift_copy && copy_reg_mode;
  assign take_irq = ce && irq_req && !mask_reg && state_reg == cmmp_pkg::ST_IDLE && !start_reg;

  // emulator-attached pin synchroniser
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      emu_s1_reg <= 1'b0;
      emu_s2_reg <= 1'b0;
    end else if (ce) begin
      emu_s1_reg <= emu_attached_pin;
      emu_s2_reg <= emu_s1_reg;
    end
  end

  // bus handshake and read data
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else if (ce) begin
      ack_reg <= acc_ok;
      if (acc_ok && avs_req.read) begin
        case (avs_req.address)
          cmmp_pkg::OFS_CTRL: rdata_reg <= ctrl_reg;
          cmmp_pkg::OFS_INSTR: rdata_reg <= instr_reg;
          cmmp_pkg::OFS_REPEAT: rdata_reg <= {16'h0000, tally_reg};
          cmmp_pkg::OFS_OPA: rdata_reg <= opa_reg;
          cmmp_pkg::OFS_OPB: rdata_reg <= opb_reg;
          cmmp_pkg::OFS_SUM: rdata_reg <= sum_reg;
          cmmp_pkg::OFS_PROD: rdata_reg <= prod_reg;
          cmmp_pkg::OFS_STATUS: rdata_reg <= {23'h00_0000, trap_reg, state_reg != cmmp_pkg::ST_IDLE,
                                              core_halted, mask_reg, pw_reg, v_reg, c_reg, n_reg, z_reg};
          cmmp_pkg::OFS_OVC: rdata_reg <= {{26{ovc_reg[5]}}, ovc_reg};
          cmmp_pkg::OFS_PROT: rdata_reg <= prot_reg;
          cmmp_pkg::OFS_PC: rdata_reg <= {10'h000, pc_reg};
          default: begin
            if (avs_req.address[7:6] == cmmp_pkg::OFS_MEM[7:6]) begin
              rdata_reg <= {16'h0000, mem_reg[avs_req.address[5:2]]};
            end else begin
              rdata_reg <= 32'h0000_0000;
            end
          end
        endcase
      end
    end
  end

  // software-written configuration and operands
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ctrl_reg <= cmmp_pkg::CTRL_RST;
      opa_reg <= 32'h0000_0000;
      opb_reg <= 32'h0000_0000;
      instr_reg <= 32'h0000_0000;
      prot_reg <= 32'h0000_0000;
    end else if (wr_ok) begin
      case (avs_req.address)
        cmmp_pkg::OFS_CTRL: ctrl_reg <= avs_req.writedata;
        cmmp_pkg::OFS_OPA: opa_reg <= avs_req.writedata;
        cmmp_pkg::OFS_OPB: opb_reg <= avs_req.writedata;
        cmmp_pkg::OFS_INSTR: instr_reg <= avs_req.writedata;
        cmmp_pkg::OFS_PROT: begin
          if (pw_reg || dbg_access) begin
            prot_reg <= avs_req.writedata;
          end
        end
        default: ;
      endcase
    end
  end

  // word memory, one process per entry
  for (genvar i = 0; i < cmmp_pkg::MEM_WORDS; i++) begin : g_mem
    logic bus_hit;
    assign bus_hit = wr_ok && avs_req.address[7:6] == cmmp_pkg::OFS_MEM[7:6] && avs_req.address[5:2] == 4'(i);
    always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
        mem_reg[i] <= 16'h0000;
      end else if (ce) begin
        if (i > 0 && copy_step && loc_idx == 4'(i - 1)) begin
          mem_reg[i] <= mem_reg[(i + cmmp_pkg::MEM_WORDS - 1) % cmmp_pkg::MEM_WORDS];
        end else if (bus_hit) begin
          mem_reg[i] <= avs_req.writedata[15:0];
        end
      end
    end
  end

  // sequencer: iteration phase, then wait cycles
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_reg <= cmmp_pkg::ST_IDLE;
      start_reg <= 1'b0;
      in_iter_reg <= 1'b0;
      iter_reg <= 16'h0000;
      wait_reg <= 2'h0;
      tally_reg <= 16'h0000;
      pc_reg <= cmmp_pkg::PC_RST;
    end else if (ce) begin
      start_reg <= wr_ok && is_instr_wr;
      if (wr_ok && avs_req.address == cmmp_pkg::OFS_REPEAT) begin
        tally_reg <= avs_req.writedata[15:0];
      end
      if (start_reg) begin
        if (trap_now) begin
          tally_reg <= 16'h0000;
        end else begin
          state_reg <= cmmp_pkg::ST_EXEC;
          in_iter_reg <= 1'b1;
          iter_reg <= rep_op ? tally_reg : 16'h0000;
          tally_reg <= 16'h0000;
          if (is_dual_mac) begin
            wait_reg <= cmmp_pkg::WAIT_MAC;
          end else if (instr_reg[15:0] == cmmp_pkg::OP_PW_EN || instr_reg[15:0] == cmmp_pkg::OP_PW_DIS) begin
            wait_reg <= cmmp_pkg::WAIT_PW;
          end else if (instr_reg[15:0] == cmmp_pkg::OP_IRQ_UNMASK) begin
            wait_reg <= cmmp_pkg::WAIT_UNMASK;
          end else begin
            wait_reg <= cmmp_pkg::WAIT_NONE;
          end
        end
      end else if (state_reg == cmmp_pkg::ST_EXEC) begin
        if (in_iter_reg) begin
          if (last_iter) begin
            in_iter_reg <= 1'b0;
          end else begin
            iter_reg <= iter_reg - 16'h0001;
          end
        end else if (wait_reg != 2'h0) begin
          wait_reg <= wait_reg - 2'h1;
        end else if (instr_reg[15:0] == cmmp_pkg::OP_BKPT && emu_live) begin
          state_reg <= cmmp_pkg::ST_HALTED;
        end else begin
          state_reg <= cmmp_pkg::ST_IDLE;
          pc_reg <= pc_reg + 22'h00_0001;
        end
      end
      // a software write of the counter wins over the closing increment
      if (wr_ok && avs_req.address == cmmp_pkg::OFS_PC) begin
        pc_reg <= avs_req.writedata[21:0];
        if (state_reg == cmmp_pkg::ST_HALTED) begin
          state_reg <= cmmp_pkg::ST_IDLE;
        end
      end
    end
  end

  // arithmetic results and flags
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sum_reg <= 32'h0000_0000;
      prod_reg <= 32'h0000_0000;
      z_reg <= 1'b0;
      n_reg <= 1'b0;
      c_reg <= 1'b0;
      v_reg <= 1'b0;
      ovc_reg <= 6'h00;
    end else if (ce) begin
      if (mac_step) begin
        sum_reg <= sum_new;
        prod_reg <= prod_reg + sh_lo;
        z_reg <= sum_new == 32'h0000_0000;
        n_reg <= sum_new[31];
        c_reg <= sum_wide[32];
        if (last_iter && !ctrl_reg[cmmp_pkg::CTRL_SAT]) begin
          if (ovf_pos) begin
            ovc_reg <= ovc_reg + 6'h01;
          end else if (ovf_neg) begin
            ovc_reg <= ovc_reg - 6'h01;
          end
        end
      end else if (wr_ok) begin
        case (avs_req.address)
          cmmp_pkg::OFS_SUM: sum_reg <= avs_req.writedata;
          cmmp_pkg::OFS_PROD: prod_reg <= avs_req.writedata;
          cmmp_pkg::OFS_OVC: ovc_reg <= avs_req.writedata[5:0];
          default: ;
        endcase
      end
      // sticky: set wins over the software clear
      if (mac_step && ovf) begin
        v_reg <= 1'b1;
      end else if (wr_ok && avs_req.address == cmmp_pkg::OFS_STATUS && avs_req.writedata[cmmp_pkg::ST_V]) begin
        v_reg <= 1'b0;
      end
    end
  end

  // protected-write bit, irq mask, trap and context save
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pw_reg <= 1'b0;
      pw_saved_reg <= 1'b0;
      mask_reg <= cmmp_pkg::RESET_IRQ_MASK;
      trap_reg <= 1'b0;
      irq_ack <= 1'b0;
    end else if (ce) begin
      irq_ack <= take_irq;
      if (take_irq || trap_now) begin
        pw_saved_reg <= pw_reg;
        pw_reg <= 1'b0;
        mask_reg <= 1'b1;
      end else if (first_step) begin
        case (instr_reg[15:0])
          cmmp_pkg::OP_PW_EN: pw_reg <= !rep_op ? 1'b1 : pw_reg;
          cmmp_pkg::OP_PW_DIS: pw_reg <= !rep_op ? 1'b0 : pw_reg;
          cmmp_pkg::OP_IRQ_UNMASK: mask_reg <= !rep_op ? 1'b0 : mask_reg;
          cmmp_pkg::OP_IRQ_RET: begin
            if (!rep_op) begin
              pw_reg <= pw_saved_reg;
              mask_reg <= 1'b0;
            end
          end
          default: ;
        endcase
      end
      if (trap_now) begin
        trap_reg <= 1'b1;
      end else if (wr_ok && avs_req.address == cmmp_pkg::OFS_STATUS && avs_req.writedata[cmmp_pkg::ST_TRAP]) begin
        trap_reg <= 1'b0;
      end
    end
  end

  // checks
  logic [2:0] age_reg;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      age_reg <= 3'h0;
    end else if (ce) begin
      age_reg <= start_reg ? 3'h1 : (age_reg != 3'h0 && age_reg != 3'h7 ? age_reg + 3'h1 : age_reg);
    end
  end
  logic pw_en_go, pw_dis_go, unmask_go;
  assign pw_en_go = start_reg && instr_reg[15:0] == cmmp_pkg::OP_PW_EN && !rep_op && !trap_now;
  assign pw_dis_go = start_reg && instr_reg[15:0] == cmmp_pkg::OP_PW_DIS && !rep_op && !trap_now;
  assign unmask_go = start_reg && instr_reg[15:0] == cmmp_pkg::OP_IRQ_UNMASK && !rep_op && !trap_now;

  pw_set_a: assert property (@(posedge clk_sys) disable iff (!nrst || !ce)
    pw_en_go |=> (state_reg != cmmp_pkg::ST_IDLE)[*4] ##1 (state_reg == cmmp_pkg::ST_IDLE && pw_reg))
    else $error("enable op wrong");
  pw_clr_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    pw_dis_go && ce |=> !pw_reg) else $error("disable op did not clear");
  unmask_a: assert property (@(posedge clk_sys) disable iff (!nrst || !ce)
    unmask_go |=> (state_reg != cmmp_pkg::ST_IDLE)[*2] ##1 (state_reg == cmmp_pkg::ST_IDLE && !mask_reg))
    else $error("unmask timing wrong");
  ctx_save_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (take_irq || trap_now) |=> !pw_reg && pw_saved_reg == $past(pw_reg)) else $error("context save wrong");
  prot_gate_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    wr_ok && avs_req.address == cmmp_pkg::OFS_PROT && !pw_reg && !dbg_access |=> $stable(prot_reg))
    else $error("protected write leaked");
  zero_flag_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    mac_step && ce |=> z_reg == (sum_reg == 32'h0000_0000) && n_reg == sum_reg[31]) else $error("flag mismatch");
  sat_clamp_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    mac_step && ce && ctrl_reg[cmmp_pkg::CTRL_SAT] && ovf_pos |=> sum_reg == cmmp_pkg::SAT_POS)
    else $error("no saturation");
  v_sticky_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    v_reg && !(wr_ok && avs_req.address == cmmp_pkg::OFS_STATUS) |=> v_reg) else $error("overflow flag dropped");
  bkpt_halt_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    core_halted && !wr_ok |=> $stable(pc_reg)) else $error("pc moved while halted");
  tally_clr_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    start_reg && ce && !rep_op |=> tally_reg == 16'h0000 && iter_reg == 16'h0000) else $error("tally kept");

  mac_rep_c: cover property (@(posedge clk_sys) disable iff (!nrst) mac_step && iter_reg == 16'h0002);
  bkpt_c: cover property (@(posedge clk_sys) disable iff (!nrst) $rose(core_halted));
  trap_c: cover property (@(posedge clk_sys) disable iff (!nrst) trap_now);
  age_c: cover property (@(posedge clk_sys) disable iff (!nrst) age_reg == 3'h4 && pw_reg);
endmodule : cmmp_core

// >>> bench/cmmp_emu_partner.sv
`timescale 1ns/1ps
module cmmp_emu_partner (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // bench commands
  input wire logic irq_cmd,
  input wire logic attach_cmd,
  // core side
  input wire logic irq_ack,
  output logic irq_req,
  output logic emu_attached_pin
);
  // request stays up until the core takes it
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) irq_req <= 1'b0;
    else if (irq_ack) irq_req <= 1'b0;
    else if (irq_cmd) irq_req <= 1'b1;
  end
  always_ff @(posedge clk_sys) begin
    emu_attached_pin <= attach_cmd;
  end
endmodule : cmmp_emu_partner

// >>> bench/cmmp_core_tb_top.sv
`timescale 1ns/1ps
module cmmp_core_tb_top;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic dbg_access = 1'b0;
  logic irq_cmd = 1'b0;
  logic attach_cmd = 1'b0;
  logic irq_req, irq_ack, emu_pin, core_halted;
  cmmp_pkg::cmmp_avs_req_t req = '0;
  cmmp_pkg::cmmp_avs_rsp_t rsp;
  logic [32:0] exp_q[$];
  logic [32:0] x;
  int err_total = 0;
  int comparisons = 0;
  int seed = 32'h5A671208;
  logic [31:0] cs[6], ca[6], cb[6], cc[6], cn[6];
  logic [31:0] s, pr, ph, pl, q;
  logic [32:0] t;
  logic of, v, c;
  logic [5:0] ovc;
  logic [3:0] fl;
  always #2.5 clk_sys = ~clk_sys;
  cmmp_core dut (.clk_sys(clk_sys), .nrst(nrst), .ce(1'b1), .avs_req(req), .avs_rsp(rsp), .dbg_access(dbg_access),
    .irq_req(irq_req), .irq_ack(irq_ack), .emu_attached_pin(emu_pin), .core_halted(core_halted));
  cmmp_emu_partner far_end (.clk_sys(clk_sys), .nrst(nrst), .irq_cmd(irq_cmd), .attach_cmd(attach_cmd),
    .irq_ack(irq_ack), .irq_req(irq_req), .emu_attached_pin(emu_pin));
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic bail;
    err_total++;
    $display("Error at %0t: wait limit reached", $time);
    end_of_test();
  endtask : bail
  // one Avalon transfer; read results are judged by the monitor
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d, input logic k, input logic [31:0] e);
    int n;
    n = 0;
    @(posedge clk_sys);
    if (!w) exp_q.push_back({k, e});
    req.address <= a;
    req.write <= w;
    req.read <= !w;
    req.writedata <= d;
    do begin
      @(posedge clk_sys);
      n++;
    end while (rsp.waitrequest !== 1'b0 && n < 100);
    if (n >= 100) bail();
    q = rsp.readdata;
    req.read <= 1'b0;
    req.write <= 1'b0;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d, 1'b0, '0);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(a, 1'b0, '0, 1'b1, e);
  endtask : rd
  task automatic exec(input logic [31:0] op, input logic halts);
    int n;
    wr(cmmp_pkg::OFS_INSTR, op);
    repeat (2) @(posedge clk_sys);
    n = 0;
    if (halts) begin
      while (core_halted !== 1'b1 && n < 50) begin
        @(negedge clk_sys);
        n++;
      end
    end else begin
      do begin
        bus(cmmp_pkg::OFS_STATUS, 1'b0, '0, 1'b0, '0);
        n++;
      end while (q[cmmp_pkg::ST_BUSY] !== 1'b0 && n < 50);
    end
    if (n >= 50) bail();
  endtask : exec
  function automatic logic [31:0] shp(input logic signed [31:0] p, input logic [3:0] amt);
    return amt[3] ? p >>> (4'h0 - amt) : p << amt;
  endfunction : shp
  always @(negedge clk_sys) begin
    if (req.read && rsp.waitrequest === 1'b0) begin
      x = exp_q.pop_front();
      if (x[32]) chk(rsp.readdata, x[31:0]);
    end
  end
  initial begin
    repeat (5) @(posedge clk_sys);
    nrst <= 1'b1;
    rd(cmmp_pkg::OFS_STATUS, 32'h0000_0020);
    rd(cmmp_pkg::OFS_CTRL, cmmp_pkg::CTRL_RST);
    cs = '{32'h0, 32'h0, 32'h0, 32'h7FFF_FFF0, 32'h7FFF_FFF0, 32'h8000_0010};
    cc = '{32'h0, 32'h10, 32'hE0, 32'h1, 32'h0, 32'h0};
    cn = '{32'h0, 32'h2, 32'h3, 32'h1, 32'h0, 32'h0};
    ca = '{32'h0, 32'h0, 32'h0, 32'h7FFF_7FFF, 32'h7FFF_7FFF, 32'h8001_0000};
    cb = '{32'h0, 32'h0, 32'h0, 32'h7FFF_7FFF, 32'h7FFF_7FFF, 32'h7FFF_0000};
    for (int k = 0; k < 3; k++) begin
      ca[k] = $random(seed);
      cb[k] = $random(seed);
      if (k > 0) cs[k] = $random(seed);
    end
    v = 1'b0;
    ovc = 6'h00;
    for (int k = 0; k < 6; k++) begin
      wr(cmmp_pkg::OFS_SUM, cs[k]);
      wr(cmmp_pkg::OFS_PROD, 32'h0);
      wr(cmmp_pkg::OFS_OPA, ca[k]);
      wr(cmmp_pkg::OFS_OPB, cb[k]);
      wr(cmmp_pkg::OFS_CTRL, cc[k]);
      wr(cmmp_pkg::OFS_REPEAT, cn[k]);
      s = cs[k];
      pr = 32'h0;
      for (int i = 0; i <= cn[k]; i++) begin
        ph = shp($signed(ca[k][31:16]) * $signed(cb[k][31:16]), cc[k][7:4]);
        pl = shp($signed(ca[k][15:0]) * $signed(cb[k][15:0]), cc[k][7:4]);
        t = {1'b0, s} + {1'b0, ph};
        of = (s[31] == ph[31]) && (t[31] != s[31]);
        v = v | of;
        c = t[32];
        if (of && cc[k][0]) t[31:0] = s[31] ? cmmp_pkg::SAT_NEG : cmmp_pkg::SAT_POS;
        if (of && !cc[k][0] && i == cn[k]) ovc = s[31] ? ovc - 6'h01 : ovc + 6'h01;
        s = t[31:0];
        pr = pr + pl;
      end
      fl = {v, c, s[31], s == 32'h0};
      exec({cmmp_pkg::OP_DUAL_MAC, cmmp_pkg::OP_MAC_W2, 8'h00}, 1'b0);
      rd(cmmp_pkg::OFS_SUM, s);
      rd(cmmp_pkg::OFS_PROD, pr);
      rd(cmmp_pkg::OFS_STATUS, {26'h0, 2'b10, fl});
      rd(cmmp_pkg::OFS_OVC, {{26{ovc[5]}}, ovc});
    end
    $display("test dual mac done");
    wr(cmmp_pkg::OFS_PROT, 32'h0000_AAAA);
    rd(cmmp_pkg::OFS_PROT, 32'h0);
    exec({16'h0, cmmp_pkg::OP_PW_EN}, 1'b0);
    rd(cmmp_pkg::OFS_STATUS, {26'h0, 2'b11, fl});
    wr(cmmp_pkg::OFS_PROT, 32'h0000_1234);
    rd(cmmp_pkg::OFS_PROT, 32'h0000_1234);
    irq_cmd <= 1'b1;
    @(posedge clk_sys);
    irq_cmd <= 1'b0;
    exec({16'h0, cmmp_pkg::OP_IRQ_UNMASK}, 1'b0);
    for (int n = 0; n < 50 && irq_req !== 1'b0; n++) @(negedge clk_sys);
    chk({31'h0, irq_req}, 32'h0);
    rd(cmmp_pkg::OFS_STATUS, {26'h0, 2'b10, fl});
    wr(cmmp_pkg::OFS_PROT, 32'h0000_5678);
    rd(cmmp_pkg::OFS_PROT, 32'h0000_1234);
    @(posedge clk_sys);
    dbg_access <= 1'b1;
    wr(cmmp_pkg::OFS_PROT, 32'h0000_5678);
    dbg_access <= 1'b0;
    rd(cmmp_pkg::OFS_PROT, 32'h0000_5678);
    exec({16'h0, cmmp_pkg::OP_IRQ_RET}, 1'b0);
    rd(cmmp_pkg::OFS_STATUS, {26'h0, 2'b01, fl});
    wr(cmmp_pkg::OFS_REPEAT, 32'h3);
    exec({16'h0, cmmp_pkg::OP_PW_DIS}, 1'b0);
    rd(cmmp_pkg::OFS_STATUS, {28'h0, fl});
    rd(cmmp_pkg::OFS_REPEAT, 32'h0);
    wr(cmmp_pkg::OFS_PROT, 32'h0000_0001);
    rd(cmmp_pkg::OFS_PROT, 32'h0000_5678);
    $display("test protection done");
    s = {16'h0, 16'($random(seed))};
    wr(8'h4C, s);
    exec({cmmp_pkg::OP_SHIFT_COPY, 8'h03, 16'h0}, 1'b0);
    rd(8'h50, s);
    rd(cmmp_pkg::OFS_STATUS, {28'h0, fl});
    exec({cmmp_pkg::OP_SHIFT_COPY, 8'hA0, 16'h0}, 1'b0);
    rd(cmmp_pkg::OFS_STATUS, {24'h1, 4'h2, fl});
    $display("test shift copy done");
    attach_cmd <= 1'b1;
    wr(cmmp_pkg::OFS_CTRL, 32'h0000_0300);
    wr(cmmp_pkg::OFS_PC, 32'h10);
    exec({16'h0, cmmp_pkg::OP_BKPT}, 1'b1);
    chk({31'h0, core_halted}, 32'h1);
    rd(cmmp_pkg::OFS_PC, 32'h10);
    wr(cmmp_pkg::OFS_PC, 32'h20);
    wr(cmmp_pkg::OFS_CTRL, 32'h0);
    chk({31'h0, core_halted}, 32'h0);
    exec({16'h0, cmmp_pkg::OP_BKPT}, 1'b0);
    rd(cmmp_pkg::OFS_PC, 32'h21);
    chk({31'h0, core_halted}, 32'h0);
    $display("test breakpoint done");
    repeat (3) @(posedge clk_sys);
    end_of_test();
  end
endmodule : cmmp_core_tb_top
